/* dv/fcf_link_monitor.sv */
/*
 Concurrent checks on the SPI wires between the host end and the flash end.
 Assumes the bench instantiates it beside the link, with a host clock divider of 8.
*/
`timescale 1ns/100ps
module fcf_link_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link wires
	input wire logic select_low_input,
	input wire logic sck,
	input wire logic si,
	input wire logic so_oe
);
	default clocking cb @(posedge clk);
	endclocking

	// Reset checks run without a disable, since reset is their cause
	a_rst_so_off: assert property (sys_rst |=> !so_oe)
		else $error("so driven after reset");
	a_rst_sel_high: assert property (sys_rst |=> select_low_input)
		else $error("select low after reset");

	// Output is released once select has stayed high past the synchronisers
	a_idle_no_drive: assert property (disable iff (sys_rst)
		select_low_input [*5] |-> !so_oe)
		else $error("so driven while deselected");
	a_oe_drop_rise: assert property (disable iff (sys_rst)
		$rose(select_low_input) |-> ##[1:4] !so_oe)
		else $error("so not released after select rise");
	a_oe_in_frame: assert property (disable iff (sys_rst)
		$rose(so_oe) |-> !select_low_input && !$past(select_low_input))
		else $error("so enabled outside a frame");

	// Host framing: data settled at each rising clock, steady half periods
	a_si_setup: assert property (disable iff (sys_rst)
		(!select_low_input && $rose(sck)) |-> $stable(si))
		else $error("si moved on sck rise");
	a_sck_half: assert property (disable iff (sys_rst)
		(!select_low_input && $changed(sck)) |=> $stable(sck) [*3])
		else $error("sck half period too short");
	// Idle clock must be steady when select falls, or the mode pick is ambiguous
	a_sel_fall_sck: assert property (disable iff (sys_rst)
		$fell(select_low_input) |-> $stable(sck))
		else $error("sck moved at select fall");
endmodule

/* dv/flash_cmd_frame_power_up_tb_top.sv */
/*
 Self-checking bench: host end and flash end joined by the link interface.
 Assumes short power-up counts (read 10, program 40) and a clock divider of 8.
*/
`timescale 1ns/100ps
module flash_cmd_frame_power_up_tb_top;
	import fcf_pkg::*;
	localparam int RW = 10;
	localparam int PW = 40;
	localparam logic [7:0] TX = 8'hC6;
	typedef struct {
		logic [7:0] op;
		logic [9:0] pg;
		logic [8:0] by;
		fcf_kind_t  k;
		logic [9:0] ep;
		logic [8:0] eb;
		int         d;
		logic [7:0] rd;
	} fcf_row_t;
	// Opcode, sent fields, expected kind and fields, dummy bytes, read bytes
	fcf_row_t rows [12] = '{
		'{8'h82, 10'h3FF, 9'h000, FCF_KIND_FULL, 10'h3FF, 9'h000, 0, 8'h00},
		'{8'h83, 10'h201, 9'h1FF, FCF_KIND_PAGE, 10'h201, 9'h000, 0, 8'h00},
		'{8'h88, 10'h155, 9'h0AA, FCF_KIND_PAGE, 10'h155, 9'h000, 0, 8'h00},
		'{8'h84, 10'h3FF, 9'h101, FCF_KIND_BUF, 10'h000, 9'h101, 0, 8'h00},
		'{8'hD1, 10'h2AA, 9'h0FF, FCF_KIND_BUF, 10'h000, 9'h0FF, 0, 8'h00},
		'{8'hD4, 10'h123, 9'h1FE, FCF_KIND_BUF, 10'h000, 9'h1FE, 1, 8'h01},
		'{8'hD2, 10'h001, 9'h1FF, FCF_KIND_FULL, 10'h001, 9'h1FF, 4, 8'h01},
		'{8'hE8, 10'h3FE, 9'h100, FCF_KIND_FULL, 10'h3FE, 9'h100, 4, 8'h01},
		'{8'h9F, 10'h3FF, 9'h1FF, FCF_KIND_NOADDR, 10'h000, 9'h000, 0, 8'h01},
		'{8'hB9, 10'h3FF, 9'h1FF, FCF_KIND_NOADDR, 10'h000, 9'h000, 0, 8'h00},
		'{8'hAB, 10'h3FF, 9'h1FF, FCF_KIND_NOADDR, 10'h000, 9'h000, 0, 8'h00},
		'{8'hD7, 10'h3FF, 9'h1FF, FCF_KIND_NOADDR, 10'h000, 9'h000, 0, 8'h01}
	};
	logic clk = 1'b0, sys_rst = 1'b1, por_active = 1'b0;
	logic req_valid = 1'b0, req_is_prog = 1'b0, req_mode3 = 1'b0;
	logic [7:0] req_opcode = 8'h00, req_rd_len = 8'h00, last_rd, op_sh;
	logic [9:0] req_page = 10'h000;
	logic [8:0] req_byte = 9'h000;
	logic [23:0] ad_sh;
	logic ready_read, ready_prog, standby, active, cmd_valid, data_phase, tx_take;
	logic req_ready, rd_valid, busy, sck_q, sel_q, last_so = 1'b0;
	logic oe_seen, act_seen;
	fcf_mode_t mode;
	fcf_kind_t cmd_kind;
	logic [7:0] cmd_opcode, rd_data;
	logic [9:0] cmd_page;
	logic [8:0] cmd_byte;
	int n_fail = 0, checked = 0, n_cmd, n_rd, n_rise, cyc, first_fall, cnt, n_take;

	fcf_link_if link ();
	// A released output shows the inverse of its last value, never a lucky match
	assign link.so_in = link.so_oe ? link.so_out : ~last_so;

	fcf_host #(.PROG_WAIT_CYC(PW), .READ_WAIT_CYC(RW), .SCK_DIV(8)) i_fcf_host (
		.clk(clk), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_opcode(req_opcode), .req_page(req_page),
		.req_byte(req_byte), .req_is_prog(req_is_prog), .req_rd_len(req_rd_len),
		.req_mode3(req_mode3), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy));
	fcf_device #(.PROG_WAIT_CYC(PW), .READ_WAIT_CYC(RW)) i_fcf_device (
		.clk(clk), .sys_rst(sys_rst), .link(link), .por_active(por_active),
		.ready_read(ready_read), .ready_prog(ready_prog), .standby(standby),
		.active(active), .mode(mode), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_kind(cmd_kind), .cmd_page(cmd_page), .cmd_byte(cmd_byte),
		.data_phase(data_phase), .tx_byte(TX), .tx_take(tx_take));
	fcf_link_monitor i_fcf_link_monitor (
		.clk(clk), .sys_rst(sys_rst), .select_low_input(link.select_low_input),
		.sck(link.sck), .si(link.si), .so_oe(link.so_oe));

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// Frame observers; the send task clears the counts before each frame
	always @(posedge clk) begin
		sck_q <= link.sck;
		sel_q <= link.select_low_input;
		if (link.so_oe === 1'b1) last_so <= link.so_out;
		if (link.so_oe === 1'b1) oe_seen <= 1'b1;
		if (active === 1'b1 && !link.select_low_input) act_seen <= 1'b1;
		if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
		if (tx_take === 1'b1) n_take <= n_take + 1;
		if (rd_valid === 1'b1) begin
			n_rd <= n_rd + 1;
			last_rd <= rd_data;
		end
		if (link.sck && !sck_q && !link.select_low_input) begin
			n_rise <= n_rise + 1;
			if (n_rise < 8) op_sh <= {op_sh[6:0], link.si};
			else if (n_rise < 32) ad_sh <= {ad_sh[22:0], link.si};
		end
		cyc <= sys_rst ? 0 : cyc + 1;
		if (sys_rst) first_fall <= 0;
		else if (first_fall == 0 && sel_q && !link.select_low_input) first_fall <= cyc;
	end

	task automatic close_out();
		if (n_fail == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic cmp_v(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic cmp_b(input string what, input logic exp, input logic got);
		cmp_v(what, {31'h0, exp}, {31'h0, got});
	endtask

	// One falling edge per call; a spent bound ends the run as a failure
	task automatic guard(inout int g);
		@(negedge clk);
		g++;
		if (g > 3000) begin
			n_fail++;
			close_out();
		end
	endtask

	// Hold the request until taken, then wait for the frame and the sync pipeline
	task automatic send(input fcf_row_t r, input logic prog, input logic m3);
		int g;
		g = 0;
		n_rise = 0;
		n_rd = 0;
		n_cmd = 0;
		n_take = 0;
		oe_seen = 1'b0;
		act_seen = 1'b0;
		{req_opcode, req_page, req_byte, req_rd_len} = {r.op, r.pg, r.by, r.rd};
		{req_is_prog, req_mode3, req_valid} = {prog, m3, 1'b1};
		while (req_ready !== 1'b1) guard(g);
		@(negedge clk);
		req_valid = 1'b0;
		while (busy !== 1'b0 || link.select_low_input !== 1'b1) guard(g);
		repeat (8) @(negedge clk);
	endtask

	task automatic reset_run();
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		cmp_b("so_oe in reset", 1'b0, link.so_oe);
		cmp_b("cmd_valid in reset", 1'b0, cmd_valid);
		cmp_v("mode in reset", FCF_MODE0, mode);
		sys_rst = 1'b0;
	endtask

	initial begin
		repeat (17) @(negedge clk);
		reset_run();
		// Read wait counted from release; program wait shown by the first frame
		cnt = 0;
		while (ready_read !== 1'b1) guard(cnt);
		cmp_b("read wait", 1'b1, cnt >= RW - 1 && cnt <= RW + 2);
		cmp_b("prog not ready", 1'b0, ready_prog);
		send(rows[0], 1'b1, 1'b0);
		cmp_b("program wait", 1'b1, first_fall >= PW - 1);
		cmp_b("active in frame", 1'b1, act_seen);
		cmp_b("standby after", 1'b1, standby);
		cmp_b("active after", 1'b0, active);
		// Table of command layouts
		for (int i = 0; i < 12; i++) begin
			send(rows[i], 1'b0, 1'b0);
			cmp_v("frames", 1, n_cmd);
			cmp_v("opcode", rows[i].op, cmd_opcode);
			cmp_v("wire opcode", rows[i].op, op_sh);
			cmp_v("kind", rows[i].k, cmd_kind);
			cmp_v("sck rises", 8 + (rows[i].k == FCF_KIND_NOADDR ? 0 : 24) +
				8 * rows[i].d + 8 * rows[i].rd, n_rise);
			cmp_v("read bytes", rows[i].rd, n_rd);
			cmp_v("bytes taken", rows[i].rd, n_take);
			cmp_b("data phase off", 1'b0, data_phase);
			cmp_b("so driven", rows[i].rd != 8'h00, oe_seen);
			if (rows[i].rd != 8'h00) cmp_v("read data", TX, last_rd);
			if (rows[i].k != FCF_KIND_NOADDR) begin
				cmp_v("page", rows[i].ep, cmd_page);
				cmp_v("byte", rows[i].eb, cmd_byte);
				cmp_v("wire addr", {5'h00, rows[i].pg, rows[i].by}, ad_sh);
			end
		end
		// Commands are ignored while the internal power-on reset is held
		por_active = 1'b1;
		send(rows[8], 1'b0, 1'b0);
		cmp_v("frames in por", 0, n_cmd);
		cmp_b("so in por", 1'b0, oe_seen);
		por_active = 1'b0;
		cnt = 0;
		while (ready_read !== 1'b1) guard(cnt);
		send(rows[8], 1'b0, 1'b0);
		cmp_v("frames after por", 1, n_cmd);
		// Mode follows the idle clock level at each select fall
		send(rows[9], 1'b0, 1'b1);
		cmp_v("mode three", FCF_MODE3, mode);
		cmp_v("frames mode three", 1, n_cmd);
		send(rows[9], 1'b0, 1'b0);
		cmp_v("mode zero", FCF_MODE0, mode);
		// Reset in mid-frame, then a clean frame must decode alone
		fork
			send(rows[6], 1'b0, 1'b0);
		join_none
		repeat (60) @(negedge clk);
		reset_run();
		wait fork;
		cnt = 0;
		while (ready_read !== 1'b1) guard(cnt);
		send(rows[8], 1'b0, 1'b0);
		cmp_v("frames after abort", 1, n_cmd);
		cmp_v("opcode after abort", 8'h9F, cmd_opcode);
		close_out();
	end
endmodule

/* src/fcf_cfg.svh */
/*
 Timing counts, opcodes and frame field positions for the flash command framer.
 Assumes a 25 MHz system clock; included by the package and both ends.
*/
`ifndef FCF_CFG_SVH
`define FCF_CFG_SVH
`define FCF_CLK_MHZ          25
`define FCF_READ_WAIT_US     70
`define FCF_PROG_WAIT_MS     3
`define FCF_READ_WAIT_CYC    ((`FCF_READ_WAIT_US * `FCF_CLK_MHZ))
`define FCF_PROG_WAIT_CYC    ((`FCF_PROG_WAIT_MS * 1000 * `FCF_CLK_MHZ))
`define FCF_RSVD_BITS        5
`define FCF_PAGE_BITS        10
`define FCF_BYTE_BITS        9
`define FCF_ADDR_BITS        24
`define FCF_PAGE_LSB         9
`define FCF_OP_PAGE_A        8'h83
`define FCF_OP_PAGE_B        8'h88
`define FCF_OP_BUF_A         8'h84
`define FCF_OP_BUF_B         8'hD1
`define FCF_OP_BUF_C         8'hD4
`define FCF_OP_DUM4_A        8'hD2
`define FCF_OP_DUM4_B        8'hE8
`define FCF_OP_ID            8'h9F
`define FCF_OP_DPD           8'hB9
`define FCF_OP_WAKE          8'hAB
`define FCF_OP_STATUS        8'hD7
`define FCF_DUM_LONG         3'h4
`define FCF_DUM_SHORT        3'h1
`define FCF_SCK_DIV          8'h08
`endif

/* src/fcf_device.sv */
/*
 Flash SPI slave front end: power-up gate, mode pick and command framing.
 Assumes select, clock and input arrive asynchronously and are synchronised here.
*/
`timescale 1ns/100ps
`include "fcf_cfg.svh"
module fcf_device
	import fcf_pkg::*;
#(
	parameter int PROG_WAIT_CYC = `FCF_PROG_WAIT_CYC,
	parameter int READ_WAIT_CYC = `FCF_READ_WAIT_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Link
	fcf_link_if.device       link,
	// Power-on reset and status
	input  wire logic        por_active,
	output logic             ready_read,
	output logic             ready_prog,
	output logic             standby,
	output logic             active,
	output fcf_mode_t        mode,
	// Decoded frame
	output logic             cmd_valid,
	output logic [7:0]       cmd_opcode,
	output fcf_kind_t        cmd_kind,
	output logic [9:0]       cmd_page,
	output logic [8:0]       cmd_byte,
	output logic             data_phase,
	// Read data to shift out
	input  wire logic [7:0]  tx_byte,
	output logic             tx_take
);
	// Elaboration check: the read wait must fit inside the program wait
	if (PROG_WAIT_CYC < 1 || READ_WAIT_CYC < 1 || READ_WAIT_CYC > PROG_WAIT_CYC) begin
		$error("fcf_device: bad wait counts");
	end

	// Synchronisers; the second stage is read as the pin, the third as its previous value for edges
	logic [2:0] sync1, sync2, sync3;
	logic [2:0] next_sync1, next_sync2, next_sync3;
	logic       cs_n, sck_s, si_s, cs_prev, sck_prev;

	always_comb begin
		next_sync1 = {link.select_low_input, link.sck, link.si};
		next_sync2 = sync1;
		next_sync3 = sync2;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			sync3 <= 3'h7;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	assign cs_n     = sync2[2];
	assign sck_s    = sync2[1];
	assign si_s     = sync2[0];
	assign cs_prev  = sync3[2];
	assign sck_prev = sync3[1];

	// Power-up wait counter; restarts whenever internal reset is held
	logic [31:0] wait_cnt, next_wait_cnt;

	always_comb begin
		next_wait_cnt = wait_cnt;
		if (por_active)
			next_wait_cnt = 32'h0;
		else if (wait_cnt < 32'(PROG_WAIT_CYC))
			next_wait_cnt = wait_cnt + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			wait_cnt <= 32'h0;
		else
			wait_cnt <= next_wait_cnt;
	end

	assign ready_read = (wait_cnt >= 32'(READ_WAIT_CYC));
	assign ready_prog = (wait_cnt >= 32'(PROG_WAIT_CYC));
	assign standby    = ready_prog && cs_n;
	assign active     = ready_prog && !cs_n;

	// Frame engine states
	typedef enum logic [4:0] {
		FCF_IDLE  = 5'h01,
		FCF_OPC   = 5'h02,
		FCF_ADDR  = 5'h04,
		FCF_DUMMY = 5'h08,
		FCF_DATA  = 5'h10
	} fcf_state_t;

	fcf_state_t  state, next_state;
	logic        armed, next_armed;
	logic [5:0]  bit_cnt, next_bit_cnt;
	logic [23:0] shreg, next_shreg;
	logic [2:0]  dum_left, next_dum_left;
	logic [7:0]  txsh, next_txsh;
	logic        so_bit, next_so_bit;
	logic        oe, next_oe;
	fcf_mode_t   next_mode;
	logic        next_valid;
	logic [7:0]  next_opcode;
	fcf_kind_t   next_kind;
	logic [9:0]  next_page;
	logic [8:0]  next_byte;
	logic        cs_fall, sck_rise, sck_fall;

	assign cs_fall  = cs_prev && !cs_n;
	assign sck_rise = !sck_prev && sck_s && !cs_n;
	assign sck_fall = sck_prev && !sck_s && !cs_n;

	// Bit-level framing; input sampled on rising, output shifted on falling
	always_comb begin
		next_state    = state;
		next_armed    = armed;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_dum_left = dum_left;
		next_txsh     = txsh;
		next_so_bit   = so_bit;
		next_oe       = oe;
		next_mode     = mode;
		next_valid    = 1'b0;
		next_opcode   = cmd_opcode;
		next_kind     = cmd_kind;
		next_page     = cmd_page;
		next_byte     = cmd_byte;
		tx_take       = 1'b0;
		if (cs_n || por_active) begin
			// Partial opcode or address is simply dropped
			next_state = FCF_IDLE;
			next_oe    = 1'b0;
			if (por_active)
				next_armed = 1'b0;
			else
				next_armed = 1'b1; // Select high seen; a fall may start a frame
		end else begin
			case (state)
				FCF_IDLE: begin
					if (cs_fall && armed && ready_read) begin
						next_mode    = sck_s ? FCF_MODE3 : FCF_MODE0;
						next_state   = FCF_OPC;
						next_bit_cnt = 6'h0;
					end
				end
				FCF_OPC: begin
					if (sck_rise) begin
						next_shreg   = {shreg[22:0], si_s};
						next_bit_cnt = bit_cnt + 6'h1;
						if (bit_cnt == 6'h7) begin
							next_opcode  = {shreg[6:0], si_s};
							next_kind    = fcf_kind({shreg[6:0], si_s});
							next_bit_cnt = 6'h0;
							if (fcf_no_addr({shreg[6:0], si_s})) begin
								next_valid = 1'b1;
								next_state = FCF_DATA;
							end else begin
								next_state = FCF_ADDR;
							end
						end
					end
				end
				FCF_ADDR: begin
					if (sck_rise) begin
						next_shreg   = {shreg[22:0], si_s};
						next_bit_cnt = bit_cnt + 6'h1;
						if (bit_cnt == 6'(`FCF_ADDR_BITS - 1)) begin
							// Top 5 bits reserved; page then byte field
							next_page = shreg[`FCF_PAGE_LSB + 8 -: `FCF_PAGE_BITS];
							next_byte = {shreg[7:0], si_s};
							// Unused field is don't-care and forced to zero
							if (cmd_kind == FCF_KIND_PAGE)
								next_byte = 9'h0;
							if (cmd_kind == FCF_KIND_BUF)
								next_page = 10'h0;
							next_bit_cnt  = 6'h0;
							next_dum_left = fcf_dummy(cmd_opcode);
							if (fcf_dummy(cmd_opcode) == 3'h0) begin
								next_valid = 1'b1;
								next_state = FCF_DATA;
							end else begin
								next_state = FCF_DUMMY;
							end
						end
					end
				end
				FCF_DUMMY: begin
					if (sck_rise) begin
						next_bit_cnt = bit_cnt + 6'h1;
						if (bit_cnt == 6'h7) begin
							next_bit_cnt  = 6'h0;
							next_dum_left = dum_left - 3'h1;
							if (dum_left == 3'h1) begin
								next_valid = 1'b1;
								next_state = FCF_DATA;
							end
						end
					end
				end
				FCF_DATA: begin
					// Output driven only after the opcode and any address and dummies
					if (sck_fall) begin
						next_oe = 1'b1;
						if (bit_cnt == 6'h0) begin
							tx_take     = 1'b1;
							next_so_bit = tx_byte[7];
							next_txsh   = {tx_byte[6:0], 1'b0};
						end else begin
							next_so_bit = txsh[7];
							next_txsh   = {txsh[6:0], 1'b0};
						end
						next_bit_cnt = (bit_cnt == 6'h7) ? 6'h0 : bit_cnt + 6'h1;
					end
				end
				default: next_state = FCF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state      <= FCF_IDLE;
			armed      <= 1'b0;
			bit_cnt    <= 6'h0;
			shreg      <= 24'h0;
			dum_left   <= 3'h0;
			txsh       <= 8'h0;
			so_bit     <= 1'b0;
			oe         <= 1'b0;
			mode       <= FCF_MODE0;
			cmd_valid  <= 1'b0;
			cmd_opcode <= 8'h0;
			cmd_kind   <= FCF_KIND_NOADDR;
			cmd_page   <= 10'h0;
			cmd_byte   <= 9'h0;
		end else begin
			state      <= next_state;
			armed      <= next_armed;
			bit_cnt    <= next_bit_cnt;
			shreg      <= next_shreg;
			dum_left   <= next_dum_left;
			txsh       <= next_txsh;
			so_bit     <= next_so_bit;
			oe         <= next_oe;
			mode       <= next_mode;
			cmd_valid  <= next_valid;
			cmd_opcode <= next_opcode;
			cmd_kind   <= next_kind;
			cmd_page   <= next_page;
			cmd_byte   <= next_byte;
		end
	end

	assign data_phase  = (state == FCF_DATA);
	assign link.so_out = so_bit;
	assign link.so_oe  = oe;
endmodule

/* src/fcf_host.sv */
/*
 Host SPI controller end: waits out power-up, then frames one command.
 Assumes the device end samples its pins through synchronisers.
*/
`timescale 1ns/100ps
`include "fcf_cfg.svh"
module fcf_host
	import fcf_pkg::*;
#(
	parameter int PROG_WAIT_CYC = `FCF_PROG_WAIT_CYC,
	parameter int READ_WAIT_CYC = `FCF_READ_WAIT_CYC,
	parameter int SCK_DIV       = `FCF_SCK_DIV
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Link
	fcf_link_if.host         link,
	// Command request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [7:0]  req_opcode,
	input  wire logic [9:0]  req_page,
	input  wire logic [8:0]  req_byte,
	input  wire logic        req_is_prog,
	input  wire logic [7:0]  req_rd_len,
	input  wire logic        req_mode3,
	// Read data
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output logic             busy
);
	// Elaboration check; below 6 the read bit crosses both pin syncs too late
	if (SCK_DIV < 6 || SCK_DIV > 255 || READ_WAIT_CYC > PROG_WAIT_CYC) begin
		$error("fcf_host: bad parameters");
	end

	// Read data arrives from the other side of the pins
	logic so_m, so_s, next_so_m, next_so_s;
	always_comb begin
		next_so_m = link.so_in;
		next_so_s = so_m;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			so_m <= 1'b0;
			so_s <= 1'b0;
		end else begin
			so_m <= next_so_m;
			so_s <= next_so_s;
		end
	end

	typedef enum logic [3:0] {
		FCH_WAIT = 4'h1,
		FCH_IDLE = 4'h2,
		FCH_SHIFT = 4'h4,
		FCH_END  = 4'h8
	} fch_state_t;

	fch_state_t  state, next_state;
	logic [31:0] pwr_cnt, next_pwr_cnt;
	logic [7:0]  div_cnt, next_div_cnt;
	logic [5:0]  out_left, next_out_left;
	logic [2:0]  dum_left, next_dum_left;
	logic [8:0]  rd_left, next_rd_left;
	logic [2:0]  bit_cnt, next_bit_cnt;
	logic [31:0] shout, next_shout;
	logic [7:0]  shin, next_shin;
	logic        cs_n, next_cs_n, sck, next_sck, idle_sck, next_idle_sck;
	logic        shift_due, next_shift_due;
	logic        next_rd_valid;
	logic [7:0]  next_rd_data;
	logic        tick;

	assign tick = (div_cnt == 8'(SCK_DIV - 1));
	// Program waits the long delay, reads the short one
	assign req_ready = (state == FCH_IDLE) &&
		(pwr_cnt >= (req_is_prog ? 32'(PROG_WAIT_CYC) : 32'(READ_WAIT_CYC)));

	always_comb begin
		next_state    = state;
		next_pwr_cnt  = (pwr_cnt < 32'(PROG_WAIT_CYC)) ? pwr_cnt + 32'h1 : pwr_cnt;
		next_div_cnt  = tick ? 8'h0 : div_cnt + 8'h1;
		next_out_left = out_left;
		next_dum_left = dum_left;
		next_rd_left  = rd_left;
		next_bit_cnt  = bit_cnt;
		next_shout    = shout;
		next_shin     = shin;
		next_cs_n     = cs_n;
		next_sck      = sck;
		next_idle_sck = idle_sck;
		next_shift_due = shift_due;
		next_rd_valid = 1'b0;
		next_rd_data  = rd_data;
		case (state)
			FCH_WAIT: begin
				if (pwr_cnt >= 32'(READ_WAIT_CYC))
					next_state = FCH_IDLE;
			end
			FCH_IDLE: begin
				next_cs_n = 1'b1;
				if (req_valid && req_ready) begin
					// Idle clock level picks the slave mode at select fall
					next_idle_sck = req_mode3;
					next_sck      = req_mode3;
					next_shout    = {req_opcode, 5'h0, req_page, req_byte};
					next_out_left = fcf_no_addr(req_opcode) ? 6'h8 : 6'h20;
					next_dum_left = fcf_dummy(req_opcode);
					next_rd_left  = {1'b0, req_rd_len};
					next_bit_cnt  = 3'h0;
					next_div_cnt  = 8'h0;
					next_shift_due = 1'b0;
					next_state    = FCH_SHIFT;
				end
			end
			FCH_SHIFT: begin
				next_cs_n = 1'b0;
				if (tick && !cs_n) begin
					next_sck = !sck;
					if (!sck) begin
						// Rising edge: device samples si here, read data taken here
						next_bit_cnt = bit_cnt + 3'h1;
						if (out_left != 6'h0) begin
							next_out_left  = out_left - 6'h1;
							next_shift_due = 1'b1;
						end else if (dum_left != 3'h0) begin
							if (bit_cnt == 3'h7)
								next_dum_left = dum_left - 3'h1;
						end else if (rd_left != 9'h0) begin
							next_shin = {shin[6:0], so_s};
							if (bit_cnt == 3'h7) begin
								next_rd_valid = 1'b1;
								next_rd_data  = {shin[6:0], so_s};
								next_rd_left  = rd_left - 9'h1;
							end
						end
						// Close on the last bit, so no spare clock reaches the device
						if (next_out_left == 6'h0 && next_dum_left == 3'h0 &&
							next_rd_left == 9'h0)
							next_state = FCH_END;
					end else if (shift_due) begin
						// Falling edge: si moves here, so it stands still over the rise
						next_shift_due = 1'b0;
						next_shout     = {shout[30:0], 1'b0};
					end
				end
			end
			FCH_END: begin
				if (tick) begin
					next_sck   = idle_sck;
					next_cs_n  = 1'b1;
					next_state = FCH_IDLE;
				end
			end
			default: next_state = FCH_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= FCH_WAIT;
			pwr_cnt  <= 32'h0;
			div_cnt  <= 8'h0;
			out_left <= 6'h0;
			dum_left <= 3'h0;
			rd_left  <= 9'h0;
			bit_cnt  <= 3'h0;
			shout    <= 32'h0;
			shin     <= 8'h0;
			cs_n     <= 1'b1;
			sck      <= 1'b0;
			idle_sck <= 1'b0;
			shift_due <= 1'b0;
			rd_valid <= 1'b0;
			rd_data  <= 8'h0;
		end else begin
			state    <= next_state;
			pwr_cnt  <= next_pwr_cnt;
			div_cnt  <= next_div_cnt;
			out_left <= next_out_left;
			dum_left <= next_dum_left;
			rd_left  <= next_rd_left;
			bit_cnt  <= next_bit_cnt;
			shout    <= next_shout;
			shin     <= next_shin;
			cs_n     <= next_cs_n;
			sck      <= next_sck;
			idle_sck <= next_idle_sck;
			shift_due <= next_shift_due;
			rd_valid <= next_rd_valid;
			rd_data  <= next_rd_data;
		end
	end

	assign busy                  = (state != FCH_IDLE);
	assign link.select_low_input = cs_n;
	assign link.sck              = sck;
	assign link.si               = shout[31];
endmodule

/* src/fcf_link_if.sv */
/*
 SPI wires between the host controller and the flash front end.
 Assumes both ends share clk; the bench resolves so from the enable.
*/
`timescale 1ns/100ps
interface fcf_link_if;
	logic select_low_input;
	logic sck;
	logic si;
	logic so_out;
	logic so_oe;
	logic so_in;

	modport device (
		input  select_low_input,
		input  sck,
		input  si,
		output so_out,
		output so_oe
	);
	modport host (
		output select_low_input,
		output sck,
		output si,
		input  so_in
	);
endinterface

/* src/fcf_pkg.sv */
/*
 Types shared by the flash command framer ends.
 Assumes fcf_cfg.svh holds the constants.
*/
`include "fcf_cfg.svh"
package fcf_pkg;
	typedef enum logic [1:0] {
		FCF_MODE0 = 2'h0,
		FCF_MODE3 = 2'h3
	} fcf_mode_t;

	typedef enum logic [2:0] {
		FCF_KIND_NOADDR = 3'h0,
		FCF_KIND_FULL   = 3'h1,
		FCF_KIND_PAGE   = 3'h2,
		FCF_KIND_BUF    = 3'h3
	} fcf_kind_t;

	// Number of extra dummy bytes after the address
	function automatic logic [2:0] fcf_dummy(input logic [7:0] op);
		if (op == `FCF_OP_DUM4_A || op == `FCF_OP_DUM4_B)
			return `FCF_DUM_LONG;
		else if (op == `FCF_OP_BUF_C)
			return `FCF_DUM_SHORT;
		else
			return 3'h0;
	endfunction

	// Opcodes that carry no address
	function automatic logic fcf_no_addr(input logic [7:0] op);
		return (op == `FCF_OP_ID) || (op == `FCF_OP_DPD) ||
			(op == `FCF_OP_WAKE) || (op == `FCF_OP_STATUS);
	endfunction

	// Which fields of the address are meaningful
	function automatic fcf_kind_t fcf_kind(input logic [7:0] op);
		if (fcf_no_addr(op))
			return FCF_KIND_NOADDR;
		else if (op == `FCF_OP_PAGE_A || op == `FCF_OP_PAGE_B)
			return FCF_KIND_PAGE;
		else if (op == `FCF_OP_BUF_A || op == `FCF_OP_BUF_B || op == `FCF_OP_BUF_C)
			return FCF_KIND_BUF;
		else
			return FCF_KIND_FULL;
	endfunction
endpackage
